// *** bench/acu_asserts.sv ***
/* port checker for acu_core.
   assumes one clock and an async active high reset. */
`timescale 1ns/1ps
module acu_asserts
   import acu_pkg::*;
(
   input logic clk,
   input logic rst,
   input logic req_valid,
   input logic req_ready,
   input acu_req_t req,
   input logic rsp_valid,
   input acu_rsp_t rsp,
   input logic mem_wr_valid,
   input logic mem_wr_ready,
   input logic [31:0] mem_wr_addr,
   input logic [31:0] mem_wr_data,
   input logic [31:0] table_base,
   input logic status_take,
   input acu_flags_t status
);
   // ****************
   // properties
   // ****************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   logic acc;
   assign acc = req_valid && req_ready;
   req_lat_a: assert property (acc && req.cls inside {cls_fixed, cls_float, cls_stf, cls_fts}
      |=> rsp_valid) else $error("short answer missing");
   flag_hold_a: assert property (status.ovf && !status_take |=> status.ovf)
      else $error("overflow flag dropped");
   flag_clear_a: assert property (status_take |=> status == '0 || rsp_valid)
      else $error("status not cleared");
   flag_cause_a: assert property ($rose(status.ovf) || $rose(status.unf) |-> rsp_valid)
      else $error("flag without answer");
   abn_cause_a: assert property ($rose(status.abn) |-> rsp_valid)
      else $error("abnormal flag without answer");
   wr_hold_a: assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid
      && $stable(mem_wr_addr) && $stable(mem_wr_data)) else $error("write not held");
   char_fmt_a: assert property (mem_wr_valid |-> (mem_wr_data & 32'hf0f0_f0f0) == 32'h0)
      else $error("character high nibble set");
   tbl_base_a: assert property (acc && req.cls inside {cls_dtf, cls_ftd}
      |=> table_base == $past(req.ea) && !req_ready) else $error("table base or busy wrong");
   half_mul_a: assert property (acc && req.cls == cls_fixed && req.fn == fn_mul
      && req.src inside {src_left, src_right} |=> rsp.wr0 && !rsp.wr1)
      else $error("half multiply wrote pair");
   pair_mul_a: assert property (acc && req.cls == cls_fixed && req.fn == fn_mul
      && req.src == src_mem && !req.dbl |=> rsp.wr0 && rsp.wr1)
      else $error("multiply not to pair");
endmodule : acu_asserts
bind acu_core acu_asserts chk_u (.clk(clk), .rst(rst), .req_valid(req_valid),
   .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
   .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
   .mem_wr_data(mem_wr_data), .table_base(table_base), .status_take(status_take),
   .status(status));

// *** bench/acu_mem_model.sv ***
/* memory side taking character words from the unit.
   assumes writes stay held until ready, one clock. */
`timescale 1ns/1ps
module acu_mem_model (
   input logic clk,
   input logic rst,
   input logic valid,
   output logic ready,
   input logic [31:0] addr,
   input logic [31:0] data
);
   logic [1:0] wait_q;
   logic n_q;
   logic [31:0] addr_q [2];
   logic [31:0] data_q [2];
   // slow word capture
   // two stall cycles per word so the hold logic is exercised
   assign ready = valid && wait_q == 2'h2;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_q <= 2'h0;
         n_q <= 1'b0;
      end else if (ready) begin
         wait_q <= 2'h0;
         addr_q[n_q] <= addr;
         data_q[n_q] <= data;
         n_q <= !n_q;
      end else if (valid) begin
         wait_q <= wait_q + 2'h1;
      end
   end
endmodule : acu_mem_model

// *** bench/testbench.sv ***
/* self-checking bench for acu_core.
   assumes the checker is bound in and the memory model answers writes. */
`timescale 1ns/1ps
module testbench
   import acu_pkg::*;
;
   logic clk, rst, req_valid, req_ready, rsp_valid, mem_wr_valid, mem_wr_ready, status_take;
   logic [31:0] mem_wr_addr, mem_wr_data, table_base;
   acu_req_t req, q;
   acu_rsp_t rsp;
   acu_flags_t status;
   int errors, tests_run, i;
   acu_core dut_u (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .mem_wr_valid(mem_wr_valid),
      .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
      .table_base(table_base), .status_take(status_take), .status(status));
   acu_mem_model mem_u (.clk(clk), .rst(rst), .valid(mem_wr_valid), .ready(mem_wr_ready),
      .addr(mem_wr_addr), .data(mem_wr_data));
   initial clk = 1'b0;
   always #12.5 clk = ~clk;
   // ****************
   // helpers
   // ****************
   task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
      tests_run++;
      if (s !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   function automatic acu_req_t mk(acu_cls_t c, acu_fn_t f, acu_src_t s,
      logic [31:0] a0, logic [31:0] a1, logic [31:0] z0, logic [31:0] z1);
      mk = '0;
      mk.cls = c;
      mk.fn = f;
      mk.src = s;
      mk.a0 = a0;
      mk.a1 = a1;
      mk.z0 = z0;
      mk.z1 = z1;
   endfunction : mk
   // long dtf/ftd runs are covered by the bounded wait
   task automatic send(input acu_req_t r);
      int k;
      @(posedge clk);
      #2 req = r;
      req_valid = 1'b1;
      @(posedge clk);
      #2 req_valid = 1'b0;
      for (k = 0; k < 500 && rsp_valid !== 1'b1; k++) begin
         @(posedge clk);
         #2;
      end
      if (k == 500) begin
         errors++;
         results();
      end
   endtask : send
   task automatic take();
      @(posedge clk);
      #2 status_take = 1'b1;
      @(posedge clk);
      #2 status_take = 1'b0;
   endtask : take
   // ****************
   // scenarios
   // ****************
   task automatic t_fixed();
      send(mk(cls_fixed, fn_add, src_mem, 32'h5, 32'h0, 32'h7, 32'h0));
      chk("add", rsp.r0, 32'hc);
      q = mk(cls_fixed, fn_add, src_mem, 32'h0, 32'hffff_ffff, 32'h0, 32'h1);
      q.dbl = 1'b1;
      send(q);
      chk("add pair", {rsp.r0, rsp.r1}, 64'h1_0000_0000);
      q.fn = fn_sub;
      q.a1 = 32'h0;
      send(q);
      chk("sub pair", {rsp.r0, rsp.r1}, '1);
      send(mk(cls_fixed, fn_add, src_left, 32'h1, 32'h0, 32'h8000_1234, 32'h0));
      chk("left half", rsp.r0, 32'hffff_8001);
      send(mk(cls_fixed, fn_add, src_right, 32'h1, 32'h0, 32'h1234_fffe, 32'h0));
      chk("right half", rsp.r0, 32'hffff_ffff);
      q = mk(cls_fixed, fn_add, src_mask, 32'h1, 32'h0, 32'h0, 32'h0);
      q.xr = 32'hff00_ff00;
      q.imm = 32'h0f0f_0f0f;
      send(q);
      chk("masked add", rsp.r0, 32'h0f00_0f01);
      q.fn = fn_sub;
      send(q);
      chk("masked sub", rsp.r0, 32'hf0ff_f101);
      q = mk(cls_fixed, fn_add, src_mem, 32'ha, 32'h0, 32'hffff_fffb, 32'h0);
      q.mag = 1'b1;
      send(q);
      chk("magnitude", rsp.r0, 32'hf);
      q = mk(cls_fixed, fn_add, src_mem, 32'h0, 32'h1, 32'hffff_ffff, 32'hffff_fffe);
      q.dbl = 1'b1;
      q.mag = 1'b1;
      send(q);
      chk("magnitude pair", {rsp.r0, rsp.r1}, 64'h3);
      send(mk(cls_fixed, fn_add, src_mem, 32'h7fff_ffff, 32'h0, 32'h1, 32'h0));
      chk("ovf", status.ovf, 1'b1);
      send(mk(cls_fixed, fn_add, src_mem, 32'h8000_0000, 32'h0, 32'hffff_ffff, 32'h0));
      chk("unf kept ovf", {status.ovf, status.unf}, 2'h3);
      take();
      chk("take", status, 3'h0);
      $display("fixed add done");
   endtask : t_fixed
   task automatic t_muldiv();
      send(mk(cls_fixed, fn_mul, src_mem, 32'h0, 32'h3, 32'hffff_fffe, 32'h0));
      chk("multiply", {rsp.r0, rsp.r1}, 64'hffff_ffff_ffff_fffa);
      // odd register equal to the even one, so only the form decides the odd write
      send(mk(cls_fixed, fn_mul, src_right, 32'h0004_0000, 32'h0004_0000, 32'h4000, 32'h0));
      chk("half mul", {rsp.wr1, rsp.r0}, 33'h1);
      send(mk(cls_fixed, fn_div, src_mem, 32'h0, 32'h64, 32'h7, 32'h0));
      chk("divide", {rsp.r0, rsp.r1}, 64'h2_0000_000e);
      send(mk(cls_fixed, fn_div, src_mem, 32'h0, 32'h64, 32'h0, 32'h0));
      chk("div zero", {rsp.wr0, rsp.wr1, status.ovf}, 3'h1);
      take();
      $display("multiply divide done");
   endtask : t_muldiv
   task automatic t_float();
      logic [31:0] a [4] = '{32'h4180_0000, 32'h4280_0000, 32'h4280_0000, 32'h4380_0000};
      logic [31:0] e [4] = '{32'h4280_0000, 32'h4180_0000, 32'h4380_0000, 32'h4280_0000};
      // every function code, sub needs renormalising
      for (i = 0; i < 4; i++) begin
         send(mk(cls_float, acu_fn_t'(i), src_mem, a[i], 32'h0,
            (i < 2) ? 32'h4180_0000 : 32'h4280_0000, 32'h0));
         chk("float op", rsp.r0, e[i]);
      end
      q = mk(cls_float, fn_add, src_mem, 32'h4180_0000, 32'h0, 32'h4180_0000, 32'h0);
      q.dbl = 1'b1;
      send(q);
      chk("float pair", {rsp.r0, rsp.r1}, 64'h4280_0000_0000_0000);
      q = mk(cls_float, fn_add, src_mem, 32'h4180_0000, 32'h0, 32'hc180_0000, 32'h0);
      q.mag = 1'b1;
      send(q);
      chk("float mag", rsp.r0, 32'h4280_0000);
      q = mk(cls_float, fn_add, src_reg, 32'h4180_0000, 32'h0, 32'h0, 32'h0);
      q.xr = 32'h4180_0000;
      q.imm = 32'hffff_ffff;
      send(q);
      chk("float reg", rsp.r0, 32'h4280_0000);
      send(mk(cls_float, fn_div, src_mem, 32'h4180_0000, 32'h0, 32'h0, 32'h0));
      chk("float div zero", status.abn, 1'b1);
      take();
      $display("float done");
   endtask : t_float
   task automatic t_conv();
      q = mk(cls_stf, fn_add, src_mem, 32'h3, 32'h0, 32'h0, 32'h0);
      q.xr = 32'h1;
      send(q);
      chk("to float", rsp.r0, 32'h41c0_0000);
      q = mk(cls_fts, fn_add, src_mem, 32'h41c0_0000, 32'h0, 32'h0, 32'h0);
      q.disp = 16'h2;
      send(q);
      chk("to scaled", rsp.r0, 32'h6);
      q = mk(cls_dtf, fn_add, src_mem, 32'h0000_0122, 32'h0, 32'h0, 32'h0);
      q.ea = 32'h1000;
      send(q);
      chk("decimal", rsp.r0, 32'h44c0_0000);
      chk("table", table_base, 32'h1000);
      send(mk(cls_dtf, fn_add, src_mem, 32'h8000_0051, 32'h1, 32'h0, 32'h0));
      chk("decimal power", rsp.r0, 32'hc6c8_0000);
      // minus one: seven scale steps, digits 10000000, power -7
      q = mk(cls_ftd, fn_add, src_mem, 32'hc180_0000, 32'h0, 32'h0, 32'h0);
      q.ea = 32'h2000;
      send(q);
      chk("ftd regs", {rsp.r0, rsp.r1}, 64'hc180_0000_ffff_fff9);
      chk("ftd table", table_base, 32'h2000);
      chk("ftd addr", {mem_u.addr_q[0], mem_u.addr_q[1]}, 64'h4180_0000_4180_0004);
      chk("ftd chars", {mem_u.data_q[0], mem_u.data_q[1]}, 64'h0100_0000_0000_0000);
      $display("conversion done");
   endtask : t_conv
   initial begin
      errors = 0;
      tests_run = 0;
      rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      status_take = 1'b0;
      repeat (16) @(posedge clk);
      #2 rst = 1'b0;
      t_fixed();
      t_muldiv();
      t_float();
      t_conv();
      results();
   end
endmodule : testbench

// *** rtl/acu_core.sv ***
/*
 * Arithmetic and conversion unit: fixed, floating and decimal forms.
 * Assumes the decoder supplies register, memory and immediate operands
 * and writes back the response; one clock, async reset.
 */
`timescale 1ns/1ps
`include "acu_map.svh"
module acu_core
   import acu_pkg::*;
(
   input logic clk,
   input logic rst,
   input logic req_valid,
   output logic req_ready,
   input acu_req_t req,
   output logic rsp_valid,
   output acu_rsp_t rsp,
   output logic mem_wr_valid,
   input logic mem_wr_ready,
   output logic [31:0] mem_wr_addr,
   output logic [31:0] mem_wr_data,
   output logic [31:0] table_base,
   input logic status_take,
   output acu_flags_t status
);
   // ****************************************
   // float helpers
   // ****************************************
   localparam acu_flt_t TEN = '{sgn: 1'b0, ex: acu_exp_t'(`ACU_TEN_EXP), man: `ACU_TEN_MAN};

   function automatic acu_flt_t f_norm(input logic s, input acu_exp_t e, input logic [64:0] m);
      acu_flt_t r;
      r.sgn = s;
      r.ex = e;
      r.man = m[63:0];
      if (m[64]) begin
         r.man = m[64:1];
         r.ex = e + 16'sd1;
      end
      for (int i = 0; i < 64; i++) begin
         if (!r.man[63]) begin
            r.man = {r.man[62:0], 1'b0};
            r.ex = r.ex - 16'sd1;
         end
      end
      if (r.man == 64'h0) begin
         r.sgn = 1'b0;
         r.ex = acu_exp_t'(`ACU_ZERO_EXP);
      end
      return r;
   endfunction : f_norm

   function automatic acu_flt_t f_unpack(input logic [31:0] w0, input logic [31:0] w1,
                                         input logic dbl);
      acu_flt_t r;
      r.sgn = w0[31];
      r.ex = acu_exp_t'({9'h0, w0[30:24]}) - acu_exp_t'(`ACU_EXP_BIAS);
      r.man = {w0[23:0], dbl ? w1 : 32'h0, 8'h0};
      // zero gets a far exponent so alignment never shifts the other side out
      if (r.man == 64'h0) begin
         r.sgn = 1'b0;
         r.ex = acu_exp_t'(`ACU_ZERO_EXP);
      end
      return r;
   endfunction : f_unpack

   // result is {ovf, unf, even word, odd word}; mantissa truncates
   function automatic logic [65:0] f_pack(input acu_flt_t f);
      acu_exp_t be;
      logic [65:0] r;
      be = f.ex + acu_exp_t'(`ACU_EXP_BIAS);
      r = {2'b00, f.sgn, be[6:0], f.man[63:8]};
      if (f.man == 64'h0) begin
         r = 66'h0;
      end else if (be > acu_exp_t'(`ACU_EXP_TOP)) begin
         r = {2'b10, f.sgn, 7'h7f, f.man[63:8]};
      end else if (be < 16'sd0) begin
         r = {2'b01, 64'h0};
      end
      return r;
   endfunction : f_pack

   function automatic logic f_abn(input logic [31:0] w);
      return (w[30:0] != 31'h0) && !w[`ACU_FRAC_MSB];
   endfunction : f_abn

   function automatic acu_flt_t f_arith(input acu_fn_t fn, input acu_flt_t x, input acu_flt_t y);
      acu_flt_t a;
      acu_flt_t b;
      acu_flt_t t;
      logic [127:0] p;
      logic [63:0] bm;
      acu_exp_t d;
      a = x;
      b = y;
      p = 128'h0;
      if (fn == fn_sub) begin
         b.sgn = ~b.sgn;
      end
      case (fn)
         fn_mul: begin
            p = a.man * b.man;
            return f_norm(a.sgn ^ b.sgn, a.ex + b.ex, {1'b0, p[127:64]});
         end
         fn_div: begin
            if (b.man != 64'h0) begin
               p = {a.man, 64'h0} / {64'h0, b.man};
            end
            return f_norm(a.sgn ^ b.sgn, a.ex - b.ex, p[64:0]);
         end
         default: begin
            if (b.ex > a.ex) begin
               t = a;
               a = b;
               b = t;
            end
            d = a.ex - b.ex;
            bm = (d > 16'sd63) ? 64'h0 : b.man >> d;
            if (a.sgn == b.sgn) begin
               return f_norm(a.sgn, a.ex, {1'b0, a.man} + {1'b0, bm});
            end
            if (a.man >= bm) begin
               return f_norm(a.sgn, a.ex, {1'b0, a.man - bm});
            end
            return f_norm(b.sgn, a.ex, {1'b0, bm - a.man});
         end
      endcase
   endfunction : f_arith

   // ****************************************
   // single-cycle operations
   // ****************************************
   typedef enum {st_idle, st_dtf, st_ftd_scale, st_ftd_dig, st_ftd_wr} acu_st_t;
   acu_st_t st_q;
   logic take;
   logic [15:0] half;
   logic [31:0] hx, b32, ma, ex_r0, ex_r1, dec_v;
   logic [63:0] x64, b64, u, un;
   logic [64:0] s65;
   logic signed [63:0] pr, q, rm, dv;
   logic fit, ex_w0, ex_w1, ex_ovf, ex_unf, ex_abn, dec_bad;
   acu_flt_t fx, fy, fr;
   logic [65:0] pk;
   acu_exp_t k, sh;
   logic [3:0] dg;

   assign req_ready = (st_q == st_idle);
   assign take = req_valid && req_ready;

   always_comb begin
      ex_r0 = 32'h0;
      ex_r1 = 32'h0;
      ex_w0 = 1'b0;
      ex_w1 = 1'b0;
      ex_ovf = 1'b0;
      ex_unf = 1'b0;
      ex_abn = 1'b0;
      half = (req.src == src_left) ? req.z0[31:16] : req.z0[15:0];
      hx = {{16{half[15]}}, half};
      // narrow operands share the full-word path
      case (req.src)
         src_left, src_right: b32 = hx;
         src_mask, src_reg: b32 = req.xr & req.imm;
         default: b32 = req.z0;
      endcase
      b64 = req.dbl ? {req.z0, req.z1} : {{32{b32[31]}}, b32};
      if (req.mag && b64[63]) begin
         b64 = -b64;
      end
      x64 = req.dbl ? {req.a0, req.a1} : {{32{req.a0[31]}}, req.a0};
      if (req.fn == fn_sub) begin
         s65 = {x64[63], x64} - {b64[63], b64};
      end else begin
         s65 = {x64[63], x64} + {b64[63], b64};
      end
      fit = req.dbl ? (s65[64] == s65[63]) : (&s65[64:31] | ~|s65[64:31]);
      // full-word multiply reads the odd register, halfword forms read the even one
      ma = (req.src == src_left || req.src == src_right) ? req.a0 : req.a1;
      pr = $signed({{32{ma[31]}}, ma}) * $signed({{32{b32[31]}}, b32});
      dv = $signed({{32{b32[31]}}, b32});
      q = (b32 == 32'h0) ? 64'sh0 : $signed({req.a0, req.a1}) / dv;
      rm = (b32 == 32'h0) ? 64'sh0 : $signed({req.a0, req.a1}) % dv;
      fx = f_unpack(req.a0, req.a1, req.dbl);
      // register form reads the index register unmasked, every other form reads z0 and z1
      fy = (req.src == src_reg) ? f_unpack(req.xr, 32'h0, req.dbl)
                                : f_unpack(req.z0, req.z1, req.dbl);
      if (req.mag) begin
         fy.sgn = 1'b0;
      end
      fr = f_arith(req.fn, fx, fy);
      k = acu_exp_t'(req.disp) + acu_exp_t'(req.xr[15:0]);
      sh = acu_exp_t'(64) - fx.ex - k;
      u = (sh > 16'sd63 || sh < 16'sd1) ? 64'h0 : fx.man >> sh;
      un = fx.sgn ? -u : u;
      // signed scaled value normalized in place
      if (req.cls == cls_stf) begin
         pk = f_pack(f_norm(x64[63], acu_exp_t'(64) - k, {1'b0, x64[63] ? -x64 : x64}));
      end else begin
         pk = f_pack(fr);
      end
      case (req.cls)
         cls_fixed: begin
            case (req.fn)
               fn_mul: begin
                  ex_r0 = pr[63:32];
                  ex_r1 = pr[31:0];
                  ex_w0 = 1'b1;
                  ex_w1 = (req.src != src_left) && (req.src != src_right);
               end
               fn_div: begin
                  ex_ovf = (b32 == 32'h0) || !(&q[63:31] | ~|q[63:31]);
                  ex_r0 = rm[31:0];
                  ex_r1 = q[31:0];
                  ex_w0 = !ex_ovf;
                  ex_w1 = !ex_ovf;
               end
               default: begin
                  // positive wrap is overflow, negative is underflow
                  ex_ovf = !fit && !s65[64];
                  ex_unf = !fit && s65[64];
                  ex_r0 = req.dbl ? s65[63:32] : s65[31:0];
                  ex_r1 = s65[31:0];
                  ex_w0 = 1'b1;
                  ex_w1 = req.dbl;
               end
            endcase
         end
         cls_float, cls_stf: begin
            ex_ovf = pk[65];
            ex_unf = pk[64];
            ex_abn = (req.cls == cls_float) && (f_abn(req.a0) || (fy.man == 64'h0 && req.fn == fn_div)
                     || f_abn((req.src == src_reg) ? req.xr : req.z0));
            ex_r0 = pk[63:32];
            ex_r1 = pk[31:0];
            ex_w0 = 1'b1;
            ex_w1 = req.dbl;
         end
         cls_fts: begin
            // truncate toward zero, refuse what does not fit
            ex_ovf = (fx.man != 64'h0) && (sh < 16'sd1 || (req.dbl ? u[63] : |u[63:31]));
            ex_r0 = req.dbl ? un[63:32] : un[31:0];
            ex_r1 = un[31:0];
            ex_w0 = !ex_ovf;
            ex_w1 = req.dbl && !ex_ovf;
         end
         default: ;
      endcase
   end

   // ****************************************
   // decimal conversions
   // ****************************************
   acu_flt_t f_q;
   logic signed [31:0] pow_q;
   logic [31:0] iv_q, addr_q, ftd_iv;
   logic [63:0] chars_q;
   logic [3:0] cnt_q;
   logic dbl_q, dtf_end, ftd_end, ftd_win, ftd_up, ftd_dn, mw_valid_q;
   logic [65:0] fpk;

   // right-adjusted digits, count in low nibble
   always_comb begin
      dec_v = 32'h0;
      dec_bad = 1'b0;
      dg = 4'h0;
      for (int i = `ACU_DIGITS - 1; i >= 0; i--) begin
         if (i < int'(req.a0[3:0])) begin
            dg = req.a0[4 * i + 4 +: 4];
            dec_v = dec_v * 32'ha + {28'h0, dg};
            dec_bad = dec_bad | (dg > 4'h9);
         end
      end
   end

   assign fpk = f_pack(f_q);
   assign dtf_end = (st_q == st_dtf) && (pow_q == 32'sh0 || f_q.man == 64'h0
                    || f_q.ex > acu_exp_t'(`ACU_EXP_LIMIT) || f_q.ex < -acu_exp_t'(`ACU_EXP_LIMIT));
   assign ftd_win = f_q.ex >= acu_exp_t'(`ACU_WIN_LO) && f_q.ex <= acu_exp_t'(`ACU_WIN_HI);
   assign ftd_iv = ftd_win ? f_q.man[63:32] >> (6'd32 - f_q.ex[5:0]) : 32'h0;
   // scale until the value holds exactly eight integer digits
   assign ftd_up = f_q.man != 64'h0 && (f_q.ex < acu_exp_t'(`ACU_WIN_LO)
                   || (ftd_win && ftd_iv < `ACU_DEC_LO));
   assign ftd_dn = f_q.man != 64'h0 && (f_q.ex > acu_exp_t'(`ACU_WIN_HI)
                   || (ftd_win && ftd_iv >= `ACU_DEC_HI));
   assign ftd_end = (st_q == st_ftd_wr) && mw_valid_q && mem_wr_ready && cnt_q[0];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= st_idle;
      end else begin
         case (st_q)
            st_idle: begin
               if (take && req.cls == cls_dtf) begin
                  st_q <= st_dtf;
               end else if (take && req.cls == cls_ftd) begin
                  st_q <= st_ftd_scale;
               end
            end
            st_dtf: if (dtf_end) st_q <= st_idle;
            st_ftd_scale: if (!ftd_up && !ftd_dn) st_q <= st_ftd_dig;
            st_ftd_dig: if (cnt_q == 4'(`ACU_CHARS - 1)) st_q <= st_ftd_wr;
            st_ftd_wr: if (ftd_end) st_q <= st_idle;
            default: st_q <= st_idle;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         f_q <= '0;
         pow_q <= 32'sh0;
         iv_q <= 32'h0;
         addr_q <= 32'h0;
         chars_q <= 64'h0;
         cnt_q <= 4'h0;
         dbl_q <= 1'b0;
      end else begin
         case (st_q)
            st_idle: begin
               dbl_q <= req.dbl;
               cnt_q <= 4'h0;
               addr_q <= {1'b0, req.a0[30:0]};
               // power of ten from odd register
               pow_q <= (req.cls == cls_ftd) ? 32'sh0 : $signed(req.a1);
               if (req.cls == cls_dtf) begin
                  f_q <= f_norm(req.a0[31], acu_exp_t'(64), {33'h0, dec_v});
               end else begin
                  f_q <= f_unpack(req.a0, req.a1, req.dbl);
               end
            end
            st_dtf, st_ftd_scale: begin
               if ((st_q == st_dtf && !dtf_end && pow_q > 32'sh0) || (st_q == st_ftd_scale && ftd_up)) begin
                  f_q <= f_arith(fn_mul, f_q, TEN);
                  pow_q <= pow_q - 32'sh1;
               end else if ((st_q == st_dtf && !dtf_end) || (st_q == st_ftd_scale && ftd_dn)) begin
                  f_q <= f_arith(fn_div, f_q, TEN);
                  pow_q <= pow_q + 32'sh1;
               end
               iv_q <= ftd_iv;
            end
            st_ftd_dig: begin
               // least digit first, upper nibble zero
               chars_q <= {4'h0, 4'(iv_q % 32'ha), chars_q[63:8]};
               iv_q <= iv_q / 32'ha;
               cnt_q <= (cnt_q == 4'(`ACU_CHARS - 1)) ? 4'h0 : cnt_q + 4'h1;
            end
            st_ftd_wr: if (mw_valid_q && mem_wr_ready) cnt_q <= cnt_q + 4'h1;
            default: ;
         endcase
      end
   end

   // ****************************************
   // memory port, response, status
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mw_valid_q <= 1'b0;
         mem_wr_addr <= 32'h0;
         mem_wr_data <= 32'h0;
      end else if (st_q == st_ftd_wr && !mw_valid_q) begin
         mw_valid_q <= 1'b1;
         mem_wr_addr <= addr_q + (cnt_q[0] ? `ACU_WORD_BYTES : 32'h0);
         mem_wr_data <= cnt_q[0] ? chars_q[31:0] : chars_q[63:32];
      end else if (mem_wr_ready) begin
         mw_valid_q <= 1'b0;
      end
   end
   assign mem_wr_valid = mw_valid_q;

   // address is only a table reference
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         table_base <= 32'h0;
      end else if (take && (req.cls == cls_dtf || req.cls == cls_ftd)) begin
         table_base <= req.ea;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rsp_valid <= 1'b0;
         rsp <= '0;
      end else begin
         rsp_valid <= 1'b0;
         if (take && req.cls != cls_dtf && req.cls != cls_ftd) begin
            rsp_valid <= 1'b1;
            rsp <= '{ex_w0, ex_w1, ex_r0, ex_r1};
         end else if (dtf_end) begin
            rsp_valid <= 1'b1;
            rsp <= '{1'b1, dbl_q, fpk[63:32], fpk[31:0]};
         end else if (ftd_end) begin
            rsp_valid <= 1'b1;
            // sign into even msb, power into odd
            rsp <= '{1'b1, 1'b1, {f_q.sgn, addr_q[30:0]}, pow_q};
         end
      end
   end

   // sticky, a new event wins over the take
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status <= '0;
      end else begin
         status.ovf <= (take & ex_ovf) | (dtf_end & fpk[65]) | (status.ovf & ~status_take);
         status.unf <= (take & ex_unf) | (dtf_end & fpk[64]) | (status.unf & ~status_take);
         status.abn <= (take & (ex_abn | (req.cls == cls_dtf && dec_bad)))
                       | (status.abn & ~status_take);
      end
   end
endmodule : acu_core

// *** rtl/acu_map.svh ***
/*
 * Constants of the arithmetic and conversion unit: field positions,
 * biases, limits and decimal ranges.
 * Assumes inclusion by both the package users and the core.
 */
`ifndef ACU_MAP_SVH
`define ACU_MAP_SVH
`define ACU_EXP_BIAS 64
`define ACU_EXP_TOP 127
`define ACU_ZERO_EXP (-16384)
`define ACU_EXP_LIMIT 512
`define ACU_FRAC_MSB 23
`define ACU_DIGITS 6
`define ACU_CHARS 8
`define ACU_TEN_EXP 4
`define ACU_TEN_MAN 64'ha000_0000_0000_0000
`define ACU_DEC_LO 32'h0098_9680
`define ACU_DEC_HI 32'h05f5_e100
`define ACU_WIN_LO 24
`define ACU_WIN_HI 27
`define ACU_WORD_BYTES 32'h4
`endif

// *** rtl/acu_pkg.sv ***
/*
 * Types of the arithmetic and conversion unit.
 * Assumes the decoder fills every request field, unused ones at zero.
 */
package acu_pkg;
   typedef logic signed [15:0] acu_exp_t;
   typedef enum logic [2:0] {cls_fixed, cls_float, cls_stf, cls_fts, cls_dtf, cls_ftd} acu_cls_t;
   typedef enum logic [1:0] {fn_add, fn_sub, fn_mul, fn_div} acu_fn_t;
   typedef enum logic [2:0] {src_mem, src_left, src_right, src_mask, src_reg} acu_src_t;
   typedef struct packed {
      acu_cls_t cls;
      acu_fn_t fn;
      acu_src_t src;
      logic mag;
      logic dbl;
      logic [31:0] a0;
      logic [31:0] a1;
      logic [31:0] xr;
      logic [31:0] imm;
      logic [31:0] z0;
      logic [31:0] z1;
      logic [15:0] disp;
      logic [31:0] ea;
   } acu_req_t;
   typedef struct packed {
      logic wr0;
      logic wr1;
      logic [31:0] r0;
      logic [31:0] r1;
   } acu_rsp_t;
   typedef struct packed {
      logic ovf;
      logic unf;
      logic abn;
   } acu_flags_t;
   typedef struct packed {
      logic sgn;
      acu_exp_t ex;
      logic [63:0] man;
   } acu_flt_t;
endpackage : acu_pkg
